// [src/sptd_defines.svh]
/*
 * Offsets, field positions and codes of the pass-through flag decoder.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef SPTD_DEFINES_SVH
`define SPTD_DEFINES_SVH
// Register byte offsets
`define SPTD_OFF_CMD_ID 8'h00
`define SPTD_OFF_CMD_W1 8'h04
`define SPTD_OFF_CDB0 8'h08
`define SPTD_OFF_CTRL 8'h0c
`define SPTD_OFF_STATUS 8'h10
`define SPTD_OFF_DONE_ID 8'h14
`define SPTD_OFF_IRQ_STAT 8'h18
`define SPTD_OFF_IRQ_MASK 8'h1c
// Command word 1 fields and CDB opcode byte
`define SPTD_W1_TID 7:0
`define SPTD_W1_AM 13:8
`define SPTD_W1_F1 23:16
`define SPTD_CDB_OPC 31:24
// Flags-1 bit positions
`define SPTD_F1_OV 7
`define SPTD_F1_ICC 5
`define SPTD_F1_IRS 3
`define SPTD_F1_DAT 2
`define SPTD_F1_DIR 1
// Control, status and interrupt bits
`define SPTD_CTRL_START 0
`define SPTD_ST_BUSY 0
`define SPTD_ST_DAT 1
`define SPTD_ST_DIR 2
`define SPTD_ST_ERR 15:8
`define SPTD_ST_CHECK 16
`define SPTD_IRQ_DONE 0
`define SPTD_IRQ_ERR 1
// Error codes and bus answers
`define SPTD_ERR_NONE 8'h00
`define SPTD_ERR_PHASE 8'h24
`define SPTD_RESP_OKAY 2'h0
`define SPTD_RESP_DECERR 2'h3
// Target pin indices in the synchroniser
`define SPTD_PIN_ACK 0
`define SPTD_PIN_IN 1
`define SPTD_PIN_OUT 2
`define SPTD_PIN_STS 3
`define SPTD_PIN_CHK 4
`define SPTD_PIN_SNS 5
`endif

// [src/sptd_pkg.sv]
/*
 * Types of the pass-through flag decoder: states and the state record.
 * Assumes nothing of its surroundings.
 */
package sptd_pkg;
  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESOLVE = 3'b001,
    ST_SELECT = 3'b010,
    ST_RUN = 3'b011,
    ST_SENSE = 3'b100
  } sptd_state_t;

  // Whole state of the top module
  typedef struct packed {
    sptd_state_t state;
    logic [5:0] sync1; // First synchroniser stage
    logic [5:0] sync2; // Second synchroniser stage
    logic awready;
    logic wready;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cmd_id;
    logic [31:0] cmd_w1;
    logic [31:0] cdb0;
    logic [1:0] irq_mask;
    logic [1:0] irq_stat;
    logic irq;
    logic busy;
    logic res_dat;
    logic res_dir;
    logic [7:0] err;
    logic check_rep;
    logic [31:0] done_id;
    logic sel_req;
    logic sense_req;
    logic xfer_en;
    logic xfer_dir;
  } sptd_st_t;
endpackage : sptd_pkg

// [src/sptd_tbl_if.sv]
/*
 * Opcode lookup link between the sequencer and the default table.
 * Assumes both ends sit in one clock domain; the lookup is combinational.
 */
`timescale 1ns/1ps
interface sptd_tbl_if;
  logic [7:0] opcode; // Opcode under lookup
  logic dat; // Default data-phase value
  logic dir; // Default direction value
  modport user (output opcode, input dat, input dir);
  modport lut (input opcode, output dat, output dir);
endinterface : sptd_tbl_if

// [src/sptd_dflt_table.sv]
/*
 * Per-opcode default data-phase and direction table.
 * Assumes the opcode is stable while the sequencer samples the answer.
 */
`timescale 1ns/1ps
module sptd_dflt_table (
  sptd_tbl_if.lut tif // Lookup link
);
  // Opcode to defaults; unlisted opcodes have no data phase
  always_comb begin
    tif.dat = 1'b0;
    tif.dir = 1'b0;
    case (tif.opcode)
      // Data in from the target
      8'h03, 8'h05, 8'h08, 8'h0f, 8'h12, 8'h14, 8'h1a, 8'h1c,
      8'h25, 8'h28, 8'h2c, 8'h2d, 8'h37, 8'h4d: begin
        tif.dat = 1'b1;
      end
      // Buffer reads take data in
      8'h3c, 8'h3e: begin
        tif.dat = 1'b1;
      end
      // Data out to the target
      8'h04, 8'h07, 8'h0a, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1d,
      8'h2a, 8'h2e, 8'h30, 8'h31, 8'h32, 8'h33, 8'h39, 8'h3a,
      8'h40, 8'h41, 8'h4c, 8'h55: begin
        tif.dat = 1'b1;
        tif.dir = 1'b1;
      end
      // Buffer writes send data out
      8'h3b, 8'h3f: begin
        tif.dat = 1'b1;
        tif.dir = 1'b1;
      end
      // Extended opcodes taking data in
      8'h5a, 8'ha4, 8'ha8, 8'hb5, 8'hb7, 8'hb8, 8'hc2, 8'hc3, 8'he4: begin
        tif.dat = 1'b1;
      end
      // Extended opcodes sending data out
      8'haa, 8'hae, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb6: begin
        tif.dat = 1'b1;
        tif.dir = 1'b1;
      end
      default: begin
        tif.dat = 1'b0;
        tif.dir = 1'b0;
      end
    endcase
  end
endmodule : sptd_dflt_table

// [src/sptd_top.sv]
/*
 * Pass-through command decoder: AXI4-Lite registers hold one command
 * block; the sequencer resolves data phase and direction, selects the
 * target, checks its bus phases and reports completion.
 * Assumes target pins are asynchronous and the bus master keeps one
 * write and one read outstanding at most.
 */
// Design decisions made here: the address map and the AXI4-Lite slave port.
// Function
// - Echo the command identifier with completion
// - Select target from target ID, deliver CDB
// - Drive six-bit address modifier on transfers
// - Flags-1 bit layout: 7,5,3,2,1
// - Direction ignored unless override and data set
// - Direction 0 in from target, 1 out
// - Data-phase 0 none, 1 data phase
// - Auto sense unless sense inhibit set
// - Completion interrupt unless inhibit set
// - Override picks host bits, else table
// - Contradicting phase ends command, error 24H
// - Table: listed opcodes are data in
// - Table: listed opcodes are data out
// - Table: other opcodes have no data
// - Table continues above 58H
`timescale 1ns/1ps
`include "sptd_defines.svh"
module sptd_top #(
  parameter int ADDR_W = 8 // Register address width
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic tgt_sel_ack, // Target answered selection
  input wire logic tgt_phase_in, // Target in data-in phase
  input wire logic tgt_phase_out, // Target in data-out phase
  input wire logic tgt_status, // Target in status phase
  input wire logic tgt_check, // Status is Check Condition
  input wire logic tgt_sense_done, // Own Request Sense finished
  output logic sel_req, // Select the target
  output logic [7:0] sel_target_id, // Target ID to select
  output logic [31:0] cdb_word, // First CDB word to deliver
  output logic sense_req, // Issue own Request Sense
  output logic xfer_en, // Data transfer cycle enable
  output logic xfer_dir, // 0 into host memory, 1 to target
  output logic [5:0] vme_am, // Address modifier for transfers
  output logic irq // Level interrupt
);
  sptd_pkg::sptd_st_t st_q; // Registered state
  sptd_pkg::sptd_st_t st_d; // Next state
  sptd_tbl_if tif (); // Default table link
  logic [7:0] f1; // Flags-1 byte of the command
  logic finish; // Command ends this cycle
  logic fin_err; // Command ends in error

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Default table lookup on the stored opcode
  assign tif.opcode = st_q.cdb0[`SPTD_CDB_OPC];
  sptd_dflt_table u_tbl (
    .tif (tif)
  );

  // Flags-1 field of command word 1
  assign f1 = st_q.cmd_w1[`SPTD_W1_F1];

  // Next-state logic: bus slave, sequencer and interrupts
  always_comb begin
    st_d = st_q;
    finish = 1'b0;
    fin_err = 1'b0;
    // Two-stage synchroniser on target pins
    st_d.sync1 = {tgt_sense_done, tgt_check, tgt_status,
                  tgt_phase_out, tgt_phase_in, tgt_sel_ack};
    st_d.sync2 = st_q.sync1;
    // Write address and data taken in either order
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    // Response consumed
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    // Sequencer
    case (st_q.state)
      sptd_pkg::ST_IDLE: begin
        // Start is taken in the write branch below
        st_d.xfer_en = 1'b0;
      end
      sptd_pkg::ST_RESOLVE: begin
        // Host bits replace the table only under override
        if (f1[`SPTD_F1_OV]) begin
          st_d.res_dat = f1[`SPTD_F1_DAT];
          st_d.res_dir = f1[`SPTD_F1_DAT] & f1[`SPTD_F1_DIR];
        end else begin
          st_d.res_dat = tif.dat;
          st_d.res_dir = tif.dir;
        end
        // Settings are fixed before selection starts
        st_d.sel_req = 1'b1;
        st_d.state = sptd_pkg::ST_SELECT;
      end
      sptd_pkg::ST_SELECT: begin
        // Hold selection until the target answers
        if (st_q.sync2[`SPTD_PIN_ACK]) begin
          st_d.sel_req = 1'b0;
          st_d.state = sptd_pkg::ST_RUN;
        end
      end
      sptd_pkg::ST_RUN: begin
        st_d.xfer_en = 1'b0;
        if (st_q.sync2[`SPTD_PIN_IN]) begin
          // Data in needs a data phase with direction 0
          if (st_q.res_dat && !st_q.res_dir) begin
            st_d.xfer_en = 1'b1;
            st_d.xfer_dir = 1'b0;
          end else begin
            finish = 1'b1;
            fin_err = 1'b1;
          end
        end else if (st_q.sync2[`SPTD_PIN_OUT]) begin
          // Data out needs a data phase with direction 1
          if (st_q.res_dat && st_q.res_dir) begin
            st_d.xfer_en = 1'b1;
            st_d.xfer_dir = 1'b1;
          end else begin
            finish = 1'b1;
            fin_err = 1'b1;
          end
        end else if (st_q.sync2[`SPTD_PIN_STS]) begin
          // Check Condition sensed here unless host asked for it
          if (st_q.sync2[`SPTD_PIN_CHK] && !f1[`SPTD_F1_IRS]) begin
            st_d.sense_req = 1'b1;
            st_d.state = sptd_pkg::ST_SENSE;
          end else begin
            st_d.check_rep = st_q.sync2[`SPTD_PIN_CHK];
            finish = 1'b1;
          end
        end
      end
      sptd_pkg::ST_SENSE: begin
        // Own Request Sense runs until its done pin
        if (st_q.sync2[`SPTD_PIN_SNS]) begin
          st_d.sense_req = 1'b0;
          finish = 1'b1;
        end
      end
      default: begin
        st_d.state = sptd_pkg::ST_IDLE;
      end
    endcase
    // Completion: identifier echoed, busy dropped
    if (finish) begin
      st_d.state = sptd_pkg::ST_IDLE;
      st_d.busy = 1'b0;
      st_d.xfer_en = 1'b0;
      st_d.done_id = st_q.cmd_id;
      st_d.err = fin_err ? `SPTD_ERR_PHASE : `SPTD_ERR_NONE;
      if (!f1[`SPTD_F1_ICC]) begin
        st_d.irq_stat[`SPTD_IRQ_DONE] = 1'b1;
      end
    end
    // Register write once address and data are both held
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `SPTD_RESP_OKAY;
      case (st_q.aw_addr)
        `SPTD_OFF_CMD_ID: begin
          // Command block is frozen while busy
          if (!st_q.busy) begin
            st_d.cmd_id = wmerge(st_q.cmd_id, st_q.w_data, st_q.w_strb);
          end
        end
        `SPTD_OFF_CMD_W1: begin
          if (!st_q.busy) begin
            st_d.cmd_w1 = wmerge(st_q.cmd_w1, st_q.w_data, st_q.w_strb);
          end
        end
        `SPTD_OFF_CDB0: begin
          if (!st_q.busy) begin
            st_d.cdb0 = wmerge(st_q.cdb0, st_q.w_data, st_q.w_strb);
          end
        end
        `SPTD_OFF_CTRL: begin
          // Start ignored while a command runs
          if (st_q.w_strb[0] && st_q.w_data[`SPTD_CTRL_START] && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.check_rep = 1'b0;
            st_d.err = `SPTD_ERR_NONE;
            st_d.state = sptd_pkg::ST_RESOLVE;
          end
        end
        `SPTD_OFF_STATUS, `SPTD_OFF_DONE_ID: begin
          // Read-only words ignore writes
          st_d.bresp = `SPTD_RESP_OKAY;
        end
        `SPTD_OFF_IRQ_STAT: begin
          // Write one to clear; a new event this cycle wins
          if (st_q.w_strb[0]) begin
            st_d.irq_stat = st_d.irq_stat & ~(st_q.w_data[1:0] & st_q.irq_stat);
            if (finish && !f1[`SPTD_F1_ICC]) begin
              st_d.irq_stat[`SPTD_IRQ_DONE] = 1'b1;
            end
          end
        end
        `SPTD_OFF_IRQ_MASK: begin
          if (st_q.w_strb[0]) begin
            st_d.irq_mask = st_q.w_data[1:0];
          end
        end
        default: begin
          st_d.bresp = `SPTD_RESP_DECERR;
        end
      endcase
    end
    // Error event is sticky until cleared
    if (fin_err) begin
      st_d.irq_stat[`SPTD_IRQ_ERR] = 1'b1;
    end
    // Register read, answered one cycle after the address
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `SPTD_RESP_OKAY;
      st_d.rdata = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        `SPTD_OFF_CMD_ID: st_d.rdata = st_q.cmd_id;
        `SPTD_OFF_CMD_W1: st_d.rdata = st_q.cmd_w1;
        `SPTD_OFF_CDB0: st_d.rdata = st_q.cdb0;
        `SPTD_OFF_CTRL: st_d.rdata = 32'h0000_0000;
        `SPTD_OFF_STATUS: begin
          st_d.rdata[`SPTD_ST_BUSY] = st_q.busy;
          st_d.rdata[`SPTD_ST_DAT] = st_q.res_dat;
          st_d.rdata[`SPTD_ST_DIR] = st_q.res_dir;
          st_d.rdata[`SPTD_ST_ERR] = st_q.err;
          st_d.rdata[`SPTD_ST_CHECK] = st_q.check_rep;
        end
        `SPTD_OFF_DONE_ID: st_d.rdata = st_q.done_id;
        `SPTD_OFF_IRQ_STAT: st_d.rdata[1:0] = st_q.irq_stat;
        `SPTD_OFF_IRQ_MASK: st_d.rdata[1:0] = st_q.irq_mask;
        default: st_d.rresp = `SPTD_RESP_DECERR;
      endcase
    end
    // Ready flags follow the next occupancy
    st_d.awready = !st_d.aw_have && !st_d.bvalid;
    st_d.wready = !st_d.w_have && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
    // Interrupt level from unmasked sticky bits
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign sel_req = st_q.sel_req;
  assign sel_target_id = st_q.cmd_w1[`SPTD_W1_TID];
  assign cdb_word = st_q.cdb0;
  assign sense_req = st_q.sense_req;
  assign xfer_en = st_q.xfer_en;
  assign xfer_dir = st_q.xfer_dir;
  assign vme_am = st_q.cmd_w1[`SPTD_W1_AM];
  assign irq = st_q.irq;

  // Checks on the sequencer
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_id_echo: assert property ($fell(st_q.busy) |-> st_q.done_id == st_q.cmd_id)
    else $error("done identifier differs from command identifier");
  chk_sel_target: assert property (sel_req |-> st_q.busy && $stable(sel_target_id))
    else $error("selected target changed during selection");
  chk_am_drive: assert property (xfer_en |-> st_q.busy && $stable(vme_am))
    else $error("address modifier changed during transfer");
  chk_dir_gate: assert property (st_q.state == sptd_pkg::ST_RESOLVE && f1[7] && !f1[2]
      |=> !st_q.res_dat && !st_q.res_dir)
    else $error("direction used without data-phase override");
  chk_override_pick: assert property (st_q.state == sptd_pkg::ST_RESOLVE && !f1[7]
      |=> st_q.res_dat == $past(tif.dat) && st_q.res_dir == $past(tif.dir))
    else $error("defaults not taken from table");
  chk_xfer_match: assert property (xfer_en |-> st_q.res_dat && xfer_dir == st_q.res_dir)
    else $error("transfer direction contradicts resolved setting");
  chk_phase_err: assert property (st_q.state == sptd_pkg::ST_RUN && st_q.sync2[1]
      && !(st_q.res_dat && !st_q.res_dir) |=> st_q.err == `SPTD_ERR_PHASE && !st_q.busy)
    else $error("unexpected phase not reported as 24H");
  chk_auto_sense: assert property (st_q.state == sptd_pkg::ST_RUN && !st_q.sync2[1]
      && !st_q.sync2[2] && st_q.sync2[3] && st_q.sync2[4] && !f1[3]
      |=> sense_req ##0 st_q.busy)
    else $error("own Request Sense not issued");
  chk_done_irq: assert property ($fell(st_q.busy) && !f1[5] |-> st_q.irq_stat[0])
    else $error("completion event not recorded");
  chk_resolve_first: assert property ($rose(sel_req) |-> $past(st_q.state) == sptd_pkg::ST_RESOLVE)
    else $error("target selected before settings resolved");

  cov_data_in: cover property (xfer_en && !xfer_dir ##[1:100] $fell(st_q.busy));
  cov_phase_err: cover property ($fell(st_q.busy) && st_q.err == 8'h24);
  cov_sense: cover property ($rose(sense_req) ##[1:100] $fell(st_q.busy));
endmodule : sptd_top

// [sim/sptd_tgt_model.sv]
/*
 * Behavioural SCSI target at the far side of the decoder.
 * Assumes the bench sets phase kind, check and speed before each start.
 */
`timescale 1ns/1ps
module sptd_tgt_model (
  input wire logic aclk, // Clock
  input wire logic sel_req, // Selection request
  input wire logic sense_req, // Own sense request
  input wire logic [1:0] kind, // Phase: 0 none, 1 in, 2 out
  input wire logic chk, // Answer with check condition
  input wire logic slow, // Answer late
  output logic tgt_sel_ack, // Selection answered
  output logic tgt_phase_in, // Data-in phase
  output logic tgt_phase_out, // Data-out phase
  output logic tgt_status, // Status phase
  output logic tgt_check, // Check condition
  output logic tgt_sense_done, // Sense finished
  output logic tgt_idle // Waiting for selection
);
  // One command per pass; all pins released between commands
  always begin
    tgt_idle <= 1'b1;
    tgt_sel_ack <= 1'b0;
    tgt_phase_in <= 1'b0;
    tgt_phase_out <= 1'b0;
    tgt_status <= 1'b0;
    tgt_check <= 1'b0;
    tgt_sense_done <= 1'b0;
    wait (sel_req === 1'b1);
    tgt_idle <= 1'b0;
    repeat (slow ? 6 : 1) @(posedge aclk);
    tgt_sel_ack <= 1'b1;
    wait (sel_req === 1'b0);
    @(posedge aclk);
    tgt_sel_ack <= 1'b0;
    tgt_phase_in <= (kind == 2'd1);
    tgt_phase_out <= (kind == 2'd2);
    repeat (4) @(posedge aclk);
    tgt_phase_in <= 1'b0;
    tgt_phase_out <= 1'b0;
    tgt_status <= 1'b1;
    tgt_check <= chk;
    repeat (5) @(posedge aclk);
    tgt_status <= 1'b0;
    tgt_check <= 1'b0;
    repeat (2) @(posedge aclk);
    // Answer the own Request Sense if one was started
    if (sense_req === 1'b1) begin
      repeat (slow ? 6 : 1) @(posedge aclk);
      tgt_sense_done <= 1'b1;
      wait (sense_req === 1'b0);
      @(posedge aclk);
    end
    @(posedge aclk);
  end
endmodule : sptd_tgt_model

// [sim/testbench.sv]
/*
 * Self-checking bench of the decoder with a target model.
 * Assumes the design header is on the include path.
 */
`timescale 1ns/1ps
`include "sptd_defines.svh"
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cdb_word;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, kind = 2'd0;
  logic tgt_sel_ack, tgt_phase_in, tgt_phase_out, tgt_status, tgt_check;
  logic tgt_sense_done, tgt_idle, sel_req, sense_req, xfer_en, xfer_dir, irq;
  logic [7:0] sel_target_id, sid;
  logic [5:0] vme_am, xam;
  logic chk = 1'b0, slow = 1'b0, xs, xd, ss;
  logic [31:0] scdb;
  int num_errors = 0, tests_run = 0, cmd_seq = 0;
  sptd_top dut (.*);
  sptd_tgt_model tgt (.*);
  always #5 aclk = ~aclk;
  // Records what the block drove during a command
  always @(posedge aclk) begin
    if (xfer_en) begin
      xs <= 1'b1;
      xd <= xfer_dir;
      xam <= vme_am;
    end
    if (sense_req) ss <= 1'b1;
    if (sel_req) sid <= sel_target_id;
    if (sel_req) scdb <= cdb_word;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One AXI4-Lite transfer; ready and answers taken at the rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic av, wv, dn;
    int n;
    n = 0;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!dn && n < 100) begin
      @(posedge aclk);
      n++;
      av = wr ? s_axi_awready : s_axi_arready;
      wv = s_axi_wready;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
      if (av) s_axi_awvalid <= 1'b0;
      if (av) s_axi_arvalid <= 1'b0;
      if (wv) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    check(dn, 1'b1);
  endtask : bus
  // Default data-phase and direction per opcode, as {dat, dir}
  function automatic logic [1:0] dflt(input logic [7:0] op);
    case (op)
      8'h03, 8'h05, 8'h08, 8'h0f, 8'h12, 8'h14, 8'h1a, 8'h1c, 8'h25, 8'h28, 8'h2c,
      8'h2d, 8'h37, 8'h3c, 8'h3e, 8'h4d, 8'h5a, 8'ha4, 8'ha8, 8'hb5, 8'hb7, 8'hb8,
      8'hc2, 8'hc3, 8'he4: return 2'b10;
      8'h04, 8'h07, 8'h0a, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1d, 8'h2a, 8'h2e, 8'h30,
      8'h31, 8'h32, 8'h33, 8'h39, 8'h3a, 8'h3b, 8'h3f, 8'h40, 8'h41, 8'h4c, 8'h55,
      8'haa, 8'hae, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb6: return 2'b11;
      default: return 2'b00;
    endcase
  endfunction : dflt
  // Loads one command block, starts it and waits for it to finish
  task automatic run_cmd(input logic [7:0] op, input logic [7:0] f1, input logic [1:0] k,
                         input logic c, output logic [31:0] st);
    logic [31:0] q, cid;
    logic [1:0] r;
    int n;
    xs = 1'b0;
    ss = 1'b0;
    cmd_seq++;
    cid = {cmd_seq[15:0], op, f1};
    kind <= k;
    chk <= c;
    slow <= op[0];
    bus(1'b1, `SPTD_OFF_CMD_ID, cid, q, r);
    bus(1'b1, `SPTD_OFF_CMD_W1, {8'h00, f1, 2'b00, op[5:0], op}, q, r);
    bus(1'b1, `SPTD_OFF_CDB0, {op, 24'h00c3a5}, q, r);
    bus(1'b1, `SPTD_OFF_CTRL, 32'h1, q, r);
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 60) begin
      bus(1'b0, `SPTD_OFF_STATUS, 32'h0, st, r);
      n++;
    end
    for (n = 0; n < 60 && !tgt_idle; n++) @(posedge aclk);
    bus(1'b0, `SPTD_OFF_DONE_ID, 32'h0, q, r);
    check(q, cid);
    check(sid, op);
    check(scdb, {op, 24'h00c3a5});
    if (xs) check(xam, op[5:0]);
  endtask : run_cmd
  task automatic t_regs;
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, `SPTD_OFF_CMD_ID, 32'h0, q, r);
    check(q, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff, q, r);
    check(r, `SPTD_RESP_DECERR);
    bus(1'b0, 8'h20, 32'h0, q, r);
    check({r, q}, {`SPTD_RESP_DECERR, 32'h0});
    bus(1'b1, `SPTD_OFF_STATUS, 32'hffff, q, r);
    bus(1'b0, `SPTD_OFF_STATUS, 32'h0, q, r);
    check(q, 32'h0);
    $display("done registers");
  endtask : t_regs
  // Every opcode with table defaults, then host flag bits with and without override
  task automatic t_resolve;
    logic [7:0] ops [6] = '{8'h04, 8'h02, 8'h02, 8'h28, 8'h02, 8'h0a};
    logic [7:0] fls [6] = '{8'h80, 8'h84, 8'h86, 8'h02, 8'h06, 8'h82};
    logic [31:0] st;
    logic [7:0] op, f1;
    logic [1:0] e;
    for (int i = 0; i < 262; i++) begin
      op = (i < 256) ? i[7:0] : ops[i-256];
      f1 = (i < 256) ? 8'h00 : fls[i-256];
      e = f1[7] ? {f1[2], f1[2] & f1[1]} : dflt(op);
      run_cmd(op, f1, e[1] ? (e[0] ? 2'd2 : 2'd1) : 2'd0, 1'b0, st);
      check(st[15:0], {8'h00, 5'h0, e[0], e[1], 1'b0});
      check(xs, e[1]);
      if (e[1]) check(xd, e[0]);
    end
    $display("done resolve");
  endtask : t_resolve
  // Phases against the resolved setting, with and without interrupt inhibit
  task automatic t_phase_err;
    logic [31:0] st, q;
    logic [1:0] r;
    bus(1'b1, `SPTD_OFF_IRQ_STAT, 32'h3, q, r);
    run_cmd(8'h08, 8'h00, 2'd2, 1'b0, st);
    check(st[15:8], `SPTD_ERR_PHASE);
    bus(1'b0, `SPTD_OFF_IRQ_STAT, 32'h0, q, r);
    check(q, 32'h3);
    bus(1'b1, `SPTD_OFF_IRQ_STAT, 32'h3, q, r);
    run_cmd(8'h00, 8'h20, 2'd1, 1'b0, st);
    check(st[15:8], `SPTD_ERR_PHASE);
    bus(1'b0, `SPTD_OFF_IRQ_STAT, 32'h0, q, r);
    check(q, 32'h2);
    $display("done phase error");
  endtask : t_phase_err
  task automatic t_sense;
    logic [31:0] st;
    run_cmd(8'h00, 8'h00, 2'd0, 1'b1, st);
    check({ss, st[16]}, 2'b10);
    run_cmd(8'h01, 8'h08, 2'd0, 1'b1, st);
    check({ss, st[16]}, 2'b01);
    $display("done sense");
  endtask : t_sense
  // Completion interrupt, its inhibit, mask and clear
  task automatic t_irq;
    logic [31:0] st, q;
    logic [1:0] r;
    bus(1'b1, `SPTD_OFF_IRQ_MASK, 32'h3, q, r);
    bus(1'b1, `SPTD_OFF_IRQ_STAT, 32'h3, q, r);
    run_cmd(8'h00, 8'h00, 2'd0, 1'b0, st);
    bus(1'b0, `SPTD_OFF_IRQ_STAT, 32'h0, q, r);
    check({q, irq}, {32'h1, 1'b1});
    bus(1'b1, `SPTD_OFF_IRQ_STAT, 32'h1, q, r);
    bus(1'b0, `SPTD_OFF_IRQ_STAT, 32'h0, q, r);
    check({q, irq}, {32'h0, 1'b0});
    run_cmd(8'h00, 8'h20, 2'd0, 1'b0, st);
    check(irq, 1'b0);
    bus(1'b1, `SPTD_OFF_IRQ_MASK, 32'h0, q, r);
    run_cmd(8'h00, 8'h00, 2'd0, 1'b0, st);
    bus(1'b0, `SPTD_OFF_IRQ_STAT, 32'h0, q, r);
    check({q, irq}, {32'h1, 1'b0});
    $display("done interrupt");
  endtask : t_irq
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_resolve();
    t_phase_err();
    t_sense();
    t_irq();
    results();
  end
  // Watchdog well above the expected run length
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    $display("FAIL %0t watchdog", $time);
    results();
  end
endmodule : testbench
